// File: rtl/dsf_defines.vh
// Constants for the drive status flag block: offsets, fields, resets, timing.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
`ifndef DSF_DEFINES_VH
`define DSF_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define DSF_OFS_CTRL 8'h00
`define DSF_OFS_TERM_SEL 8'h04
`define DSF_OFS_HS_LEVEL 8'h08
`define DSF_OFS_LL_THRESH 8'h0c
`define DSF_OFS_USER_OUT 8'h10
`define DSF_OFS_STATUS 8'h14
`define DSF_OFS_INT_STAT 8'h18
`define DSF_OFS_INT_MASK 8'h1c
`define DSF_OFS_LIFE 8'h20

// ****************************************
// Field positions
// ****************************************
`define DSF_CTRL_FAN_LSB 0
`define DSF_CTRL_FAN_MSB 1
`define DSF_CTRL_RUN_LSB 4
`define DSF_CTRL_RUN_MSB 5
`define DSF_SEL_W 6
`define DSF_SEL_STRIDE 8
`define DSF_ST_CAP 0
`define DSF_ST_FAN 1
`define DSF_ST_CMD 2
`define DSF_ST_HOT 3
`define DSF_ST_LL 4
`define DSF_ST_CONFLICT 5
`define DSF_ST_W 6

// ****************************************
// Selection codes
// ****************************************
`define DSF_CODE_CAP 6'h27
`define DSF_CODE_FAN 6'h28
`define DSF_CODE_CMD 6'h29
`define DSF_CODE_HOT 6'h2a
`define DSF_CODE_LL 6'h2b
`define DSF_CODE_UP1 6'h2c
`define DSF_CODE_UP2 6'h2d
`define DSF_CODE_UP3 6'h2e

// ****************************************
// Reset values and fixed settings
// ****************************************
`define DSF_RST_CTRL 32'h0000_0000
`define DSF_RST_TERM_SEL 32'h0000_0000
`define DSF_RST_HS_LEVEL 32'h0000_0064
`define DSF_RST_LL_THRESH 32'h0000_0000
`define DSF_RST_MASK 32'h0000_0000
`define DSF_FAN_MODE_STOPPABLE 2'h1
`define DSF_FAN_PCT 75
`define DSF_PCT_FULL 100

// ****************************************
// Timing
// ****************************************
`define DSF_CLK_PERIOD_NS 20
`define DSF_LIFE_TICK_NS 1000000000
`define DSF_LIFE_TICK_CYCLES (`DSF_LIFE_TICK_NS / `DSF_CLK_PERIOD_NS)

`endif

// File: rtl/dsf_cap_life.v
// Capacitor life estimator: integrates powered-on time weighted by temperature.
// Assumes temperature is an unsigned code sampled on clk_sys.
`timescale 1ns/100ps
module dsf_cap_life #(
  parameter TICK_CYCLES = 50000000,
  parameter LIFE_LIMIT = 32'h0100_0000,
  parameter [7:0] TEMP_REF = 8'h28
)(
  input wire clk_sys,
  input wire arst_n,
  input wire [7:0] temp_in,
  output reg [31:0] life_used_reg,
  output reg expired_reg
);

  reg [31:0] tick_cnt_reg;
  reg [31:0] life_used_next;
  wire tick;
  wire [7:0] temp_over;
  wire [31:0] weight;

  assign tick = (tick_cnt_reg == TICK_CYCLES - 1);
  assign temp_over = (temp_in > TEMP_REF) ? (temp_in - TEMP_REF) : 8'h00;
  // Hotter parts age faster: one extra unit per 8 degrees above reference
  assign weight = {27'h0, temp_over[7:3]} + 32'h0000_0001;

  always @*
  begin
    life_used_next = life_used_reg;
    if (tick && !expired_reg)
    begin
      life_used_next = life_used_reg + weight;
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_cnt_reg <= 32'h0;
      life_used_reg <= 32'h0;
      expired_reg <= 1'b0;
    end
    else
    begin
      tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
      life_used_reg <= life_used_next;
      expired_reg <= (life_used_next >= LIFE_LIMIT);
    end
  end

endmodule // dsf_cap_life

// File: rtl/dsf_term_mux.v
// Output terminal router: each terminal carries the flag its code selects.
// Assumes flags are on clk_sys; unknown codes drive the terminal low.
`timescale 1ns/100ps
`include "dsf_defines.vh"
module dsf_term_mux #(
  parameter N_TERM = 3
)(
  input wire clk_sys,
  input wire arst_n,
  input wire [`DSF_SEL_STRIDE*N_TERM-1:0] sel_in,
  input wire [7:0] flags_in,
  output wire [N_TERM-1:0] term_out
);

  genvar gi;
  generate
    for (gi = 0; gi < N_TERM; gi = gi + 1)
    begin : g_term
      wire [`DSF_SEL_W-1:0] code;
      reg out_reg;
      reg out_next;
      assign code = sel_in[`DSF_SEL_STRIDE*gi +: `DSF_SEL_W];
      always @*
      begin
        case (code)
          `DSF_CODE_CAP: out_next = flags_in[0];
          `DSF_CODE_FAN: out_next = flags_in[1];
          `DSF_CODE_CMD: out_next = flags_in[2];
          `DSF_CODE_HOT: out_next = flags_in[3];
          `DSF_CODE_LL: out_next = flags_in[4];
          `DSF_CODE_UP1: out_next = flags_in[5];
          `DSF_CODE_UP2: out_next = flags_in[6];
          `DSF_CODE_UP3: out_next = flags_in[7];
          default: out_next = 1'b0;
        endcase
      end
      always @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
        begin
          out_reg <= 1'b0;
        end
        else
        begin
          out_reg <= out_next;
        end
      end
      assign term_out[gi] = out_reg;
    end
  endgenerate

endmodule // dsf_term_mux

// File: rtl/dsf_top.v
// Drive status flag generator with APB register access and one interrupt.
// Assumes all sensor and command inputs are synchronous to clk_sys.
//
// Summary of operation
// - Code 39 terminal shows capacitor_life_warning while estimated life is expired.
// - Capacitor life estimated from internal temperature and powered-on time.
// - Code 40 terminal shows fan_slow_warning when fan speed falls to 75%.
// - Fan control setting 01 keeps fan_slow_warning low, even fan stopped.
// - fan_slow_warning state readable in the status monitor register.
// - Code 41 flag derives from commands regardless of run source selection.
// - command_present_flag low only when forward and reverse both active.
// - Both direction commands active stops motor drive.
// - Code 42 shows heatsink_hot_warning while temperature exceeds warn level.
// - light_load_flag high while output current below light load threshold.
// - Codes 44 to 46 carry user program outputs 1 to 3 as commanded.
`timescale 1ns/100ps
`include "dsf_defines.vh"
module dsf_top #(
  parameter N_TERM = 3,
  parameter TICK_CYCLES = `DSF_LIFE_TICK_CYCLES,
  parameter LIFE_LIMIT = 32'h0100_0000,
  parameter [15:0] FAN_FULL_SPEED = 16'h0bb8
)(
  input wire clk_sys,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] internal_temp,
  input wire [7:0] heatsink_temp,
  input wire [15:0] fan_speed,
  input wire [15:0] output_current,
  input wire forward_command,
  input wire reverse_command,
  output wire [N_TERM-1:0] term_out,
  output reg motor_run_enable,
  output wire irq
);

  // ****************************************
  // Write masks and reset words
  // ****************************************
  localparam [31:0] CTRL_WMASK = 32'h0000_0033;
  localparam [31:0] SEL_WMASK = 32'h003f_3f3f;
  localparam [31:0] HS_RST_WORD = `DSF_RST_HS_LEVEL;
  localparam [31:0] LL_RST_WORD = `DSF_RST_LL_THRESH;

  // ****************************************
  // Register storage
  // ****************************************
  reg [31:0] ctrl_reg;
  reg [31:0] term_sel_reg;
  reg [7:0] hs_level_reg;
  reg [15:0] ll_thresh_reg;
  reg [2:0] user_out_reg;
  reg [`DSF_ST_W-1:0] status_reg;
  reg [`DSF_ST_W-1:0] status_prev_reg;
  reg [`DSF_ST_W-1:0] int_stat_reg;
  wire [`DSF_ST_W-1:0] int_stat_next;
  wire int_rd_clear;
  reg [`DSF_ST_W-1:0] int_mask_reg;
  reg [31:0] rdata_next;
  reg addr_ok;

  wire [1:0] fan_control_setting;
  wire [1:0] run_source_select;
  wire [31:0] life_used;
  wire cap_expired;
  wire [31:0] fan_scaled;
  wire [31:0] fan_limit;
  wire fan_raw;
  reg [`DSF_ST_W-1:0] status_next;
  wire [`DSF_ST_W-1:0] events;
  wire setup;
  wire access;
  wire wr_en;
  wire rd_en;
  wire [7:0] flags;

  assign fan_control_setting = ctrl_reg[`DSF_CTRL_FAN_MSB:`DSF_CTRL_FAN_LSB];
  // Kept for software only; the command flag does not look at it
  assign run_source_select = ctrl_reg[`DSF_CTRL_RUN_MSB:`DSF_CTRL_RUN_LSB];

  // ****************************************
  // Capacitor life estimate
  // ****************************************
  dsf_cap_life #(
    .TICK_CYCLES(TICK_CYCLES),
    .LIFE_LIMIT(LIFE_LIMIT)
  ) u_cap_life (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .temp_in(internal_temp),
    .life_used_reg(life_used),
    .expired_reg(cap_expired)
  );

  // ****************************************
  // Flag derivation
  // ****************************************
  // Compare speed*100 against full*75 without a divider
  assign fan_scaled = {16'h0000, fan_speed} * `DSF_PCT_FULL;
  assign fan_limit = {16'h0000, FAN_FULL_SPEED} * `DSF_FAN_PCT;
  assign fan_raw = (fan_scaled <= fan_limit);

  always @*
  begin
    status_next = {`DSF_ST_W{1'b0}};
    status_next[`DSF_ST_CAP] = cap_expired;
    // Setting 01 silences the fan warning, even with the fan stopped
    if (fan_raw && (fan_control_setting != `DSF_FAN_MODE_STOPPABLE))
    begin
      status_next[`DSF_ST_FAN] = 1'b1;
    end
    // Run source selection is not consulted
    if (!(forward_command && reverse_command))
    begin
      status_next[`DSF_ST_CMD] = 1'b1;
    end
    else
    begin
      status_next[`DSF_ST_CONFLICT] = 1'b1;
    end
    if (heatsink_temp > hs_level_reg)
    begin
      status_next[`DSF_ST_HOT] = 1'b1;
    end
    if (output_current < ll_thresh_reg)
    begin
      status_next[`DSF_ST_LL] = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_reg <= {`DSF_ST_W{1'b0}};
      status_prev_reg <= {`DSF_ST_W{1'b0}};
    end
    else
    begin
      status_reg <= status_next;
      status_prev_reg <= status_reg;
    end
  end

  // Drive interlock: both direction commands stop the motor
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      motor_run_enable <= 1'b0;
    end
    else
    begin
      motor_run_enable <= !(forward_command && reverse_command);
    end
  end

  // ****************************************
  // Terminal routing
  // ****************************************
  assign flags = {user_out_reg, status_reg[`DSF_ST_LL:`DSF_ST_CAP]};

  dsf_term_mux #(
    .N_TERM(N_TERM)
  ) u_term_mux (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sel_in(term_sel_reg[`DSF_SEL_STRIDE*N_TERM-1:0]),
    .flags_in(flags),
    .term_out(term_out)
  );

  // ****************************************
  // APB slave
  // ****************************************
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && !addr_ok;
  assign wr_en = access && pwrite && addr_ok;
  assign rd_en = access && !pwrite && addr_ok;

  always @*
  begin
    addr_ok = 1'b1;
    case (paddr)
      `DSF_OFS_CTRL: addr_ok = 1'b1;
      `DSF_OFS_TERM_SEL: addr_ok = 1'b1;
      `DSF_OFS_HS_LEVEL: addr_ok = 1'b1;
      `DSF_OFS_LL_THRESH: addr_ok = 1'b1;
      `DSF_OFS_USER_OUT: addr_ok = 1'b1;
      `DSF_OFS_STATUS: addr_ok = 1'b1;
      `DSF_OFS_INT_STAT: addr_ok = 1'b1;
      `DSF_OFS_INT_MASK: addr_ok = 1'b1;
      `DSF_OFS_LIFE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always @*
  begin
    rdata_next = 32'h0;
    case (paddr)
      `DSF_OFS_CTRL: rdata_next = ctrl_reg;
      `DSF_OFS_TERM_SEL: rdata_next = term_sel_reg;
      `DSF_OFS_HS_LEVEL: rdata_next = {24'h0, hs_level_reg};
      `DSF_OFS_LL_THRESH: rdata_next = {16'h0, ll_thresh_reg};
      `DSF_OFS_USER_OUT: rdata_next = {29'h0, user_out_reg};
      `DSF_OFS_STATUS: rdata_next = {26'h0, status_reg};
      `DSF_OFS_INT_STAT: rdata_next = {26'h0, int_stat_reg};
      `DSF_OFS_INT_MASK: rdata_next = {26'h0, int_mask_reg};
      `DSF_OFS_LIFE: rdata_next = life_used;
      default: rdata_next = 32'h0;
    endcase
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata <= 32'h0;
    end
    else if (setup && !pwrite)
    begin
      prdata <= rdata_next;
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg <= `DSF_RST_CTRL;
      term_sel_reg <= `DSF_RST_TERM_SEL;
      hs_level_reg <= HS_RST_WORD[7:0];
      ll_thresh_reg <= LL_RST_WORD[15:0];
      user_out_reg <= 3'h0;
      int_mask_reg <= {`DSF_ST_W{1'b0}};
    end
    else if (wr_en)
    begin
      case (paddr)
        `DSF_OFS_CTRL: ctrl_reg <= pwdata & CTRL_WMASK;
        `DSF_OFS_TERM_SEL: term_sel_reg <= pwdata & SEL_WMASK;
        `DSF_OFS_HS_LEVEL: hs_level_reg <= pwdata[7:0];
        `DSF_OFS_LL_THRESH: ll_thresh_reg <= pwdata[15:0];
        `DSF_OFS_USER_OUT: user_out_reg <= pwdata[2:0];
        `DSF_OFS_INT_MASK: int_mask_reg <= pwdata[`DSF_ST_W-1:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // Rising edge of any status flag is an event
  assign events = status_reg & ~status_prev_reg;

  assign int_rd_clear = rd_en && (paddr == `DSF_OFS_INT_STAT);

  genvar bi;
  generate
    for (bi = 0; bi < `DSF_ST_W; bi = bi + 1)
    begin : g_int
      reg bit_next;
      always @*
      begin
        bit_next = int_stat_reg[bi];
        if (int_rd_clear)
        begin
          bit_next = 1'b0;
        end
        // Set wins over read clear
        if (events[bi])
        begin
          bit_next = 1'b1;
        end
      end
      assign int_stat_next[bi] = bit_next;
    end
  endgenerate

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int_stat_reg <= {`DSF_ST_W{1'b0}};
    end
    else
    begin
      int_stat_reg <= int_stat_next;
    end
  end

  assign irq = |(int_stat_reg & int_mask_reg);

endmodule // dsf_top

// File: testbench/dsf_load_model.sv
// Load model: external loads latching each output terminal.
// Assumes terminals are synchronous to clk_sys.
`timescale 1ns/100ps
module dsf_load_model #(
  parameter N_TERM = 3
)(
  input wire clk_sys,
  input wire arst_n,
  input wire [N_TERM-1:0] term_out,
  output logic [N_TERM-1:0] load_on
);
  always @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      load_on <= '0;
    else
      load_on <= term_out;
endmodule // dsf_load_model

// File: testbench/dsf_chk.sv
// Checker for the status flag block: bus answer, drive stop, interrupt.
// Assumes it is bound to dsf_top and sees only its ports.
`timescale 1ns/100ps
module dsf_chk (
  input wire clk_sys,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire forward_command,
  input wire reverse_command,
  input wire motor_run_enable,
  input wire irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire both = forward_command && reverse_command;
  wire acc = psel && penable;
  property p_stop; both |=> !motor_run_enable; endproperty
  a_stop: assert property (p_stop) else $error("drive on with both commands");
  property p_run; !both |=> motor_run_enable; endproperty
  a_run: assert property (p_run) else $error("drive off without conflict");
  property p_run_rise; $rose(motor_run_enable) |-> !$past(both); endproperty
  a_run_rise: assert property (p_run_rise) else $error("drive rose on conflict");
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
  property p_err_only; pslverr |-> acc; endproperty
  a_err_only: assert property (p_err_only) else $error("error outside access");
  property p_err_map; acc && paddr > 8'h20 |-> pslverr; endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped not refused");
  property p_err_ok; acc && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_err_ok: assert property (p_err_ok) else $error("mapped refused");
  property p_irq_hold; irq && !psel |=> irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped idle");
  c_both: cover property (both);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
endmodule // dsf_chk
bind dsf_top dsf_chk dsf_chk_inst (.clk_sys, .arst_n, .psel, .penable, .paddr, .pready,
  .pslverr, .forward_command, .reverse_command, .motor_run_enable, .irq);

// File: testbench/testbench.sv
// Self-checking bench for dsf_top with a load model on the terminals.
// Assumes short life ticks: TICK_CYCLES 4, LIFE_LIMIT 8.
`timescale 1ns/100ps
module testbench;
  logic clk_sys, arst_n, psel, penable, pwrite, forward_command, reverse_command, err;
  logic [7:0] paddr, internal_temp, heatsink_temp;
  logic [15:0] fan_speed, output_current;
  logic [31:0] pwdata, rdat;
  wire [31:0] prdata;
  wire pready, pslverr, motor_run_enable, irq;
  wire [2:0] term_out, load_on;
  int fails, check_count;
  dsf_top #(.TICK_CYCLES(4), .LIFE_LIMIT(32'h8)) dsf_top_inst (.clk_sys, .arst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .internal_temp,
    .heatsink_temp, .fan_speed, .output_current, .forward_command, .reverse_command,
    .term_out, .motor_run_enable, .irq);
  dsf_load_model dsf_load_model_inst (.clk_sys, .arst_n, .term_out, .load_on);
  initial
  begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ****
  // Shared tasks
  // ****
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      report_and_stop;
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never drives psel twice in one step
    @(posedge clk_sys);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    apb(0, 8'h08, 0);
    chk(rdat, 32'h64);
    apb(0, 8'h04, 0);
    chk(rdat, 0);
    apb(0, 8'h1c, 0);
    chk(rdat, 0);
    apb(0, 8'h40, 0);
    chk(rdat, 32'h0);
    chk(err, 1'b1);
    $display("t_regs done");
  endtask
  task automatic t_cap;
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    cyc(1);
    apb(1, 8'h04, 32'h27);
    cyc(14);
    chk(load_on[0], 0);
    internal_temp <= 8'h58;
    cyc(12);
    chk(load_on[0], 1);
    $display("t_cap done");
  endtask
  task automatic t_cmd;
    apb(1, 8'h00, 32'h30);
    apb(1, 8'h04, 32'h2b2a29);
    for (int i = 3; i >= 0; i--)
    begin
      {forward_command, reverse_command} <= i[1:0];
      cyc(4);
      chk(load_on[0], i != 3);
      chk(motor_run_enable, i != 3);
    end
    $display("t_cmd done");
  endtask
  task automatic t_sense;
    apb(1, 8'h08, 32'h50);
    apb(1, 8'h0c, 32'h100);
    heatsink_temp <= 8'h50;
    output_current <= 16'h100;
    cyc(4);
    chk(load_on[2:1], 0);
    heatsink_temp <= 8'h51;
    output_current <= 16'h0ff;
    cyc(4);
    chk(load_on[2:1], 3);
    $display("t_sense done");
  endtask
  task automatic t_fan;
    apb(1, 8'h04, 32'h28);
    fan_speed <= 16'd2250;
    cyc(4);
    chk(load_on[0], 1);
    apb(0, 8'h14, 0);
    chk(rdat[1], 1);
    fan_speed <= 16'd2251;
    cyc(4);
    chk(load_on[0], 0);
    apb(1, 8'h00, 32'h1);
    fan_speed <= 16'h0;
    cyc(4);
    chk(load_on[0], 0);
    $display("t_fan done");
  endtask
  task automatic t_user;
    apb(1, 8'h04, 32'h2e2d2c);
    for (int v = 0; v < 8; v++)
    begin
      apb(1, 8'h10, v);
      cyc(3);
      chk(load_on, v[2:0]);
    end
    $display("t_user done");
  endtask
  task automatic t_irq;
    for (int m = 1; m >= 0; m--)
    begin
      apb(1, 8'h1c, {m[0], 3'h0});
      heatsink_temp <= 8'h0;
      cyc(4);
      apb(0, 8'h18, 0);
      heatsink_temp <= 8'h51;
      cyc(4);
      chk(irq, m);
      apb(0, 8'h18, 0);
      chk(rdat[3], 1);
      cyc(1);
      chk(irq, 0);
    end
    $display("t_irq done");
  endtask
  initial
  begin
    {psel, penable, pwrite, forward_command, reverse_command} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    internal_temp = 8'h0;
    heatsink_temp = 8'h0;
    fan_speed = 16'hffff;
    output_current = 16'hffff;
    fails = 0;
    check_count = 0;
    arst_n = 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    cyc(1);
    t_regs;
    t_cap;
    t_cmd;
    t_sense;
    t_fan;
    t_user;
    t_irq;
    report_and_stop;
  end
endmodule // testbench
